// >>> rtl/reset_timer_watchdog.sv
// Overview of operation
// - Erased pin-enable fuse: pin is active-low reset
// - Programmed fuse: internal reset inactive, pin input
// - Power-up sets latch, clears reset timer
// - Timer counts only while pin high; clears latch
// - Processor held in reset while timer active
// - Period by oscillator mode and reset type
// - Reset timer runs from dedicated RC tick
// - Watchdog timeout in sleep restarts reset timer
// - Four reset sources: power, pin, watchdog, wake
// - Watchdog counts from own RC, also asleep
// - Watchdog timeout resets, waking from sleep too
// - Watchdog reset clears active-low timeout flag
// - Watchdog fuse zero disables watchdog permanently
// - Base timeout 18 ms, prescaler up to 1:128
// - Clear instruction resets watchdog, and prescaler if assigned to it
// - Sleep instruction resets watchdog, and prescaler if assigned to it
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rtw_defines.svh"

module reset_timer_watchdog #(
  parameter int unsigned RC_DIV          = `RC_DIV_CYCLES,
  parameter int unsigned DRT_LONG_TICKS  = `DRT_LONG_TICKS,
  parameter int unsigned DRT_SHORT_TICKS = `DRT_SHORT_TICKS,
  parameter int unsigned WDT_BASE_TICKS  = `WDT_BASE_TICKS
) (
  input  wire logic                clock,            // 100 MHz system clock
  input  wire logic                nrst,             // Power-on reset, active low
  input  wire rtw_pkg::config_type fuses,            // Configuration word bits
  input  wire logic                shared_reset_input_pin, // Shared reset/input pin level
  input  wire logic                pin_change_wake,  // Wake-on-change detected
  input  wire logic                psel,             // APB select
  input  wire logic                penable,          // APB enable
  input  wire logic                pwrite,           // APB direction
  input  wire logic [11:0]         paddr,            // APB byte address
  input  wire logic [31:0]         pwdata,           // APB write data
  output logic      [31:0]         prdata,           // APB read data
  output logic                     pready,           // APB ready
  output logic                     pslverr,          // APB error on unmapped address
  output logic                     core_reset,       // Processor reset, active high
  output logic                     general_input,    // Pin value as a plain input
  output rtw_pkg::option_type      option_bits,      // Option register to timer logic
  output logic                     irq               // Level interrupt
);

  // ==========================================================
  // Register bus decode
  logic setup_phase;
  logic access_wr;
  logic hit_option;
  logic hit_status;
  logic hit_command;
  logic hit_irq_status;
  logic hit_irq_clear;
  logic hit_irq_enable;
  logic mapped;

  assign setup_phase    = psel & ~penable;
  assign access_wr      = psel & penable & pwrite;
  assign hit_option     = (paddr == `ADDR_OPTION);
  assign hit_status     = (paddr == `ADDR_STATUS);
  assign hit_command    = (paddr == `ADDR_COMMAND);
  assign hit_irq_status = (paddr == `ADDR_IRQ_STATUS);
  assign hit_irq_clear  = (paddr == `ADDR_IRQ_CLEAR);
  assign hit_irq_enable = (paddr == `ADDR_IRQ_ENABLE);
  assign mapped         = hit_option | hit_status | hit_command | hit_irq_status
                        | hit_irq_clear | hit_irq_enable;
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & ~mapped;

  logic wr_option;
  logic wr_command;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic clear_instr;
  logic sleep_instr;

  assign wr_option     = access_wr & hit_option;
  assign wr_command    = access_wr & hit_command;
  assign wr_irq_clear  = access_wr & hit_irq_clear;
  assign wr_irq_enable = access_wr & hit_irq_enable;
  assign clear_instr   = wr_command & pwdata[`CMD_CLEAR_BIT];
  assign sleep_instr   = wr_command & pwdata[`CMD_SLEEP_BIT];

  // ==========================================================
  // Dedicated RC oscillator, modelled as a tick enable
  logic [15:0] rc_div_q;
  logic        rc_tick;

  assign rc_tick = (rc_div_q == 16'(RC_DIV - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rc_div_q <= 16'h0000;
    end else begin
      rc_div_q <= rc_tick ? 16'h0000 : rc_div_q + 16'h0001;
    end
  end

  // ==========================================================
  // Reset pin selection
  logic reset_pin_n;

  // Programmed fuse ties the pin's reset function inactive
  assign reset_pin_n   = fuses.reset_pin_enable ? shared_reset_input_pin : 1'b1;
  assign general_input = shared_reset_input_pin;

  // ==========================================================
  // Sequencer state
  rtw_pkg::seq_state_type state_q;
  rtw_pkg::seq_state_type state_d;
  logic [31:0] drt_cnt_q;
  logic        drt_long_q;
  logic        drt_long_d;
  logic [31:0] wdt_cnt_q;
  logic [6:0]  pre_cnt_q;
  logic        timeout_flag_n_q;
  logic        power_down_n_q;
  rtw_pkg::option_type option_q;
  logic [`IRQ_WIDTH-1:0] irq_stat_q;
  logic [`IRQ_WIDTH-1:0] irq_en_q;

  logic pin_reset;
  logic wake_reset;
  logic wdt_timeout;
  logic any_reset;
  logic crystal_mode;
  logic drt_period_end;
  logic [31:0] drt_limit;

  assign crystal_mode = (fuses.osc_mode == rtw_pkg::high_speed_crystal_mode)
                      | (fuses.osc_mode == rtw_pkg::standard_crystal_mode)
                      | (fuses.osc_mode == rtw_pkg::low_power_crystal_mode);
  assign pin_reset    = ~reset_pin_n;
  assign wake_reset   = pin_change_wake & (state_q == rtw_pkg::st_sleep);
  assign any_reset    = pin_reset | wake_reset | wdt_timeout;
  // Crystals always need the long start-up time
  assign drt_long_d   = crystal_mode;
  assign drt_limit    = drt_long_q ? 32'(DRT_LONG_TICKS) : 32'(DRT_SHORT_TICKS);
  assign drt_period_end = rc_tick & (drt_cnt_q >= drt_limit - 32'd1);

  // Hold until pin high, then count ticks until the period ends
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rtw_pkg::st_hold: begin
        if (reset_pin_n) begin
          state_d = rtw_pkg::st_count;
        end
      end
      rtw_pkg::st_count: begin
        if (drt_period_end) begin
          state_d = rtw_pkg::st_run;
        end
      end
      rtw_pkg::st_run: begin
        if (sleep_instr) begin
          state_d = rtw_pkg::st_sleep;
        end
      end
      rtw_pkg::st_sleep: begin
        state_d = rtw_pkg::st_sleep;
      end
    endcase
    if (any_reset) begin
      state_d = rtw_pkg::st_hold;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q    <= rtw_pkg::st_hold;
      drt_long_q <= 1'b1;
    end else begin
      state_q <= state_d;
      // A pin reset during the power-up hold must not shorten the power-up period
      if (any_reset && (state_q == rtw_pkg::st_run || state_q == rtw_pkg::st_sleep)) begin
        drt_long_q <= drt_long_d;
      end
    end
  end

  // ==========================================================
  // Device reset timer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drt_cnt_q <= 32'h0000_0000;
    end else if (state_q != rtw_pkg::st_count || any_reset) begin
      drt_cnt_q <= 32'h0000_0000;
    end else if (rc_tick) begin
      drt_cnt_q <= drt_cnt_q + 32'd1;
    end
  end

  // Latch is the hold and count states; the pin also resets directly
  assign core_reset = (state_q == rtw_pkg::st_hold) | (state_q == rtw_pkg::st_count)
                    | pin_reset;

  // ==========================================================
  // Watchdog and shared prescaler
  logic       wdt_enabled;
  logic       wdt_clear;
  logic       pre_to_wdt;
  logic       wdt_step;
  logic [6:0] pre_mask;

  assign wdt_enabled = fuses.watchdog_fuse_enable;
  assign pre_to_wdt  = option_q.prescaler_assign;
  assign pre_mask    = 7'((8'h01 << option_q.prescale_rate) - 8'h01);
  // Clears also on every device reset, so each wake starts fresh
  assign wdt_clear   = clear_instr | sleep_instr | any_reset;
  assign wdt_step    = rc_tick & (~pre_to_wdt | ((pre_cnt_q & pre_mask) == pre_mask));
  assign wdt_timeout = wdt_enabled & wdt_step
                     & (wdt_cnt_q == 32'(WDT_BASE_TICKS) - 32'd1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt_q <= 32'h0000_0000;
      pre_cnt_q <= 7'h00;
    end else if (!wdt_enabled) begin
      wdt_cnt_q <= 32'h0000_0000;
      pre_cnt_q <= 7'h00;
    end else if (wdt_clear) begin
      wdt_cnt_q <= 32'h0000_0000;
      if (pre_to_wdt) begin
        pre_cnt_q <= 7'h00;
      end
    end else begin
      if (rc_tick && pre_to_wdt) begin
        pre_cnt_q <= pre_cnt_q + 7'h01;
      end
      if (wdt_step) begin
        wdt_cnt_q <= wdt_cnt_q + 32'd1;
      end
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timeout_flag_n_q <= 1'b1;
      power_down_n_q   <= 1'b1;
    end else if (wdt_timeout) begin
      timeout_flag_n_q <= 1'b0;
    end else if (clear_instr) begin
      timeout_flag_n_q <= 1'b1;
      power_down_n_q   <= 1'b1;
    end else if (sleep_instr) begin
      timeout_flag_n_q <= 1'b1;
      power_down_n_q   <= 1'b0;
    end
  end

  // ==========================================================
  // Option register, back to all ones on any device reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      option_q <= `OPTION_RESET;
    end else if (any_reset) begin
      option_q <= `OPTION_RESET;
    end else if (wr_option) begin
      option_q <= pwdata[7:0];
    end
  end

  assign option_bits = option_q;

  // ==========================================================
  // Interrupts: set wins over a clear in the same cycle
  logic [`IRQ_WIDTH-1:0] irq_events;

  assign irq_events[`IRQ_WDT_BIT]     = wdt_timeout;
  assign irq_events[`IRQ_PIN_BIT]     = pin_reset;
  assign irq_events[`IRQ_WAKE_BIT]    = wake_reset;
  assign irq_events[`IRQ_RELEASE_BIT] = drt_period_end & (state_q == rtw_pkg::st_count);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq_clear ? pwdata[`IRQ_WIDTH-1:0] : '0))
                  | irq_events;
      if (wr_irq_enable) begin
        irq_en_q <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ==========================================================
  // Read data, captured in the setup phase
  logic [31:0] status_word;
  logic [31:0] read_mux;

  assign status_word = {27'h0, timeout_flag_n_q, power_down_n_q, 2'b00,
                        (state_q == rtw_pkg::st_sleep)};
  // Option register is write-only and reads as zero
  assign read_mux = hit_status     ? status_word
                  : hit_irq_status ? {28'h0, irq_stat_q}
                  : hit_irq_enable ? {28'h0, irq_en_q}
                  : 32'h0000_0000;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end

endmodule

// >>> rtl/rtw_defines.svh
`ifndef RTW_DEFINES_SVH
`define RTW_DEFINES_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS    10
`define RC_TICK_NS       1000
`define RC_DIV_CYCLES    (`RC_TICK_NS / `CLK_PERIOD_NS)
`define DRT_LONG_US      18000
`define DRT_SHORT_US     10
`define WDT_BASE_US      18000
`define DRT_LONG_TICKS   ((`DRT_LONG_US * 1000) / `RC_TICK_NS)
`define DRT_SHORT_TICKS  ((`DRT_SHORT_US * 1000) / `RC_TICK_NS)
`define WDT_BASE_TICKS   ((`WDT_BASE_US * 1000) / `RC_TICK_NS)

// ==========================================================
// Register map (byte addresses)
`define ADDR_OPTION      12'h000
`define ADDR_STATUS      12'h004
`define ADDR_COMMAND     12'h008
`define ADDR_IRQ_STATUS  12'h00C
`define ADDR_IRQ_CLEAR   12'h010
`define ADDR_IRQ_ENABLE  12'h014

// ==========================================================
// Fields and reset values
`define OPTION_RESET     8'hFF
`define STATUS_TO_BIT    4
`define STATUS_PD_BIT    3
`define STATUS_SLEEP_BIT 0
`define CMD_CLEAR_BIT    0
`define CMD_SLEEP_BIT    1
`define IRQ_WDT_BIT      0
`define IRQ_PIN_BIT      1
`define IRQ_WAKE_BIT     2
`define IRQ_RELEASE_BIT  3
`define IRQ_WIDTH        4

`endif

// >>> rtl/rtw_pkg.sv
package rtw_pkg;

  typedef enum logic [2:0] {
    internal_osc_mode       = 3'b000,
    external_rc_mode        = 3'b001,
    external_clock_mode     = 3'b010,
    high_speed_crystal_mode = 3'b011,
    standard_crystal_mode   = 3'b100,
    low_power_crystal_mode  = 3'b101
  } osc_mode_type;

  typedef struct packed {
    logic         reset_pin_enable;
    logic         watchdog_fuse_enable;
    osc_mode_type osc_mode;
  } config_type;

  typedef struct packed {
    logic       pin_wake_disable;
    logic       pullup_disable;
    logic       timer_clock_source;
    logic       timer_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_rate;
  } option_type;

  typedef enum logic [1:0] {
    st_hold  = 2'b00,
    st_count = 2'b01,
    st_run   = 2'b10,
    st_sleep = 2'b11
  } seq_state_type;

endpackage

// >>> sim/ext_reset_circuit.sv
`timescale 1ns/1ps

module ext_reset_circuit (
  input  wire logic press,    // Reset switch closed
  output logic      pin_level // Level seen at the reset pin
);
  // ==========================================================
  // Switch to ground with a pull-up: an open switch lets the pin rise
  assign pin_level = press ? 1'b0 : 1'b1;
endmodule

// >>> sim/rtw_props.sv
`timescale 1ns/1ps
`include "rtw_defines.svh"

module rtw_props #(
  parameter int unsigned RC_DIV          = `RC_DIV_CYCLES,
  parameter int unsigned DRT_LONG_TICKS  = `DRT_LONG_TICKS,
  parameter int unsigned DRT_SHORT_TICKS = `DRT_SHORT_TICKS
) (
  input wire logic                clock,                  // Clock
  input wire logic                nrst,                   // Reset
  input wire rtw_pkg::config_type fuses,                  // Fuses
  input wire logic                shared_reset_input_pin, // Pin
  input wire logic                pin_change_wake,        // Wake
  input wire logic                psel,                   // Select
  input wire logic                penable,                // Enable
  input wire logic                pwrite,                 // Direction
  input wire logic [11:0]         paddr,                  // Address
  input wire logic [31:0]         pwdata,                 // Write data
  input wire logic [31:0]         prdata,                 // Read data
  input wire logic                pready,                 // Ready
  input wire logic                pslverr,                // Error
  input wire logic                core_reset,             // Core reset
  input wire logic                general_input,          // Pin copy
  input wire rtw_pkg::option_type option_bits             // Option
);
  localparam int unsigned LONG_CYC  = DRT_LONG_TICKS * RC_DIV;
  localparam int unsigned SHORT_CYC = DRT_SHORT_TICKS * RC_DIV;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        por_q;
  logic        pin_up;
  logic        access;
  // ==========================================================
  // Cycles in reset with the pin released; pin low restarts the count
  assign pin_up = shared_reset_input_pin || !fuses.reset_pin_enable;
  assign cnt_d  = (core_reset && pin_up) ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
  assign access = psel && penable;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 32'h0000_0000;
      por_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      por_q <= por_q && core_reset;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_opt_write;
    access && pwrite && paddr == `ADDR_OPTION && !core_reset;
  endsequence
  AST_PIN_RESET: assert property (fuses.reset_pin_enable && !shared_reset_input_pin |-> core_reset)
    else $error("core reset low while pin held low");
  AST_GPIN: assert property (general_input == shared_reset_input_pin)
    else $error("plain input differs from pin");
  AST_POR_LONG: assert property ($fell(core_reset) && por_q |-> cnt_q >= LONG_CYC - 3)
    else $error("power-up release too early");
  AST_HOLD_MAX: assert property (core_reset |-> cnt_q <= LONG_CYC + 4)
    else $error("reset held too long after pin release");
  AST_RELEASE_MIN: assert property ($fell(core_reset) |-> cnt_q >= SHORT_CYC - 2)
    else $error("reset released before timer period");
  AST_SLVERR: assert property (access && paddr[1:0] == 2'b00
    |-> pready && pslverr == (paddr > `ADDR_IRQ_ENABLE))
    else $error("bad error answer");
  AST_READ_ZERO: assert property (access && !pwrite && paddr == `ADDR_OPTION
    |-> prdata == 32'h0000_0000)
    else $error("option read not zero");
  AST_OPT_WRITE: assert property (s_opt_write |=> option_bits == $past(pwdata[7:0]))
    else $error("option write lost");
  AST_OPT_RESET: assert property ($rose(core_reset) |-> ##[0:2] option_bits == 8'hFF)
    else $error("option not all ones after reset");
  AST_CAUSE: assert property ($rose(core_reset) && !fuses.watchdog_fuse_enable
    |-> (fuses.reset_pin_enable && !shared_reset_input_pin)
        || pin_change_wake || $past(pin_change_wake))
    else $error("reset without a source");
endmodule

bind reset_timer_watchdog rtw_props #(
  .RC_DIV(RC_DIV), .DRT_LONG_TICKS(DRT_LONG_TICKS), .DRT_SHORT_TICKS(DRT_SHORT_TICKS)
) PROPS (
  .clock(clock), .nrst(nrst), .fuses(fuses), .shared_reset_input_pin(shared_reset_input_pin),
  .pin_change_wake(pin_change_wake), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_reset(core_reset), .general_input(general_input), .option_bits(option_bits)
);

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "rtw_defines.svh"

module tb;
  localparam int LONG  = 40;
  localparam int SHORT = 6;
  localparam int BASE  = 20;
  logic                clock;
  logic                nrst    = 1'b0;
  rtw_pkg::config_type fuses   = '{1'b1, 1'b0, rtw_pkg::internal_osc_mode};
  logic                press   = 1'b0;
  logic                pin;
  logic                wake    = 1'b0;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [11:0]         paddr   = 12'h000;
  logic [31:0]         pwdata  = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                core_reset;
  logic                general_input;
  rtw_pkg::option_type option_bits;
  logic                irq;
  logic [31:0]         rd;
  logic                err;
  int                  n;
  int                  fails       = 0;
  int                  checks_done = 0;

  // Short counts: 2-clock tick, long 20 ticks, short 3 ticks, watchdog 10 ticks
  reset_timer_watchdog #(.RC_DIV(2), .DRT_LONG_TICKS(20), .DRT_SHORT_TICKS(3),
    .WDT_BASE_TICKS(10)) DUT (
    .clock(clock), .nrst(nrst), .fuses(fuses), .shared_reset_input_pin(pin),
    .pin_change_wake(wake), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_reset(core_reset), .general_input(general_input), .option_bits(option_bits),
    .irq(irq));
  ext_reset_circuit PARTNER (.press(press), .pin_level(pin));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // Shared tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_span(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      fails++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts settled samples until core reset reaches lvl, giving up after max
  task automatic wait_for(input logic lvl, input int max);
    n = 0;
    @(negedge clock);
    while (core_reset !== lvl && n < max) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic drive(input logic p, input logic w);
    @(posedge clock);
    press <= p;
    wake <= w;
  endtask
  task automatic por(input rtw_pkg::config_type f);
    @(posedge clock);
    nrst <= 1'b0;
    fuses <= f;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_por();
    drive(1'b1, 1'b0);
    por('{1'b1, 1'b0, rtw_pkg::internal_osc_mode});
    wait_for(1'b0, 60);
    cmp_span("held while pin low", 60, 60, n);
    drive(1'b0, 1'b0);
    wait_for(1'b0, 200);
    cmp_span("power-up release", LONG - 3, LONG + 3, n);
    cmp("option reset", 32'h0000_00FF, {24'h00_0000, option_bits});
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    cmp("status power-up", 32'h0000_0018, rd & 32'h0000_0019);
  endtask
  task automatic t_modes();
    int e;
    for (int m = 0; m < 6; m++) begin
      por('{1'b1, 1'b0, rtw_pkg::osc_mode_type'(3'(m))});
      wait_for(1'b0, 200);
      drive(1'b1, 1'b0);
      wait_for(1'b0, 10);
      cmp_span("pin reset held", 10, 10, n);
      drive(1'b0, 1'b0);
      e = (m < 3) ? SHORT : LONG;
      wait_for(1'b0, 200);
      cmp_span("pin reset period", e - 2, e + 3, n);
    end
  endtask
  task automatic t_pin_off();
    por('{1'b0, 1'b0, rtw_pkg::internal_osc_mode});
    wait_for(1'b0, 200);
    apb(1'b1, `ADDR_OPTION, 32'h0000_00F0);
    drive(1'b1, 1'b0);
    wait_for(1'b1, 100);
    cmp_span("no pin or watchdog reset", 100, 100, n);
    cmp("plain input", 32'h0000_0000, {31'h0000_0000, general_input});
    drive(1'b0, 1'b0);
  endtask
  task automatic t_rate();
    logic [3:0] sel [4] = '{4'h8, 4'h9, 4'hA, 4'h2};
    int         e;
    por('{1'b1, 1'b1, rtw_pkg::internal_osc_mode});
    wait_for(1'b0, 200);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `ADDR_OPTION, {24'h00_0000, 4'hF, sel[k]});
      apb(1'b1, `ADDR_COMMAND, 32'h0000_0001);
      e = sel[k][3] ? (BASE << sel[k][2:0]) : BASE;
      wait_for(1'b1, 400);
      cmp_span("watchdog period", e - 4, e + 4, n);
      wait_for(1'b0, 200);
    end
  endtask
  task automatic t_wdt();
    apb(1'b1, `ADDR_IRQ_CLEAR, 32'h0000_000F);
    apb(1'b1, `ADDR_OPTION, 32'h0000_00F0);
    repeat (8) apb(1'b1, `ADDR_COMMAND, 32'h0000_0001);
    wait_for(1'b1, 1);
    cmp_span("no timeout while cleared", 1, 1, n);
    wait_for(1'b1, 40);
    cmp_span("timeout after clears", BASE - 8, BASE + 4, n);
    wait_for(1'b0, 40);
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    cmp("status timeout", 32'h0000_0000, rd & 32'h0000_0010);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0001);
    @(negedge clock);
    cmp("irq enabled", 32'h0000_0001, {31'h0000_0000, irq});
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0000);
    @(negedge clock);
    cmp("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, `ADDR_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0001);
    @(negedge clock);
    cmp("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
  endtask
  task automatic t_sleep();
    apb(1'b1, `ADDR_OPTION, 32'h0000_00F0);
    apb(1'b1, `ADDR_COMMAND, 32'h0000_0002);
    wait_for(1'b1, 60);
    cmp_span("full period asleep", BASE - 4, BASE + 4, n);
    wait_for(1'b0, 60);
    cmp_span("timer restarted", SHORT - 2, SHORT + 4, n);
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    cmp("status sleep timeout", 32'h0000_0000, rd & 32'h0000_0018);
    apb(1'b1, `ADDR_COMMAND, 32'h0000_0002);
    drive(1'b0, 1'b1);
    wait_for(1'b1, 10);
    cmp_span("wake asleep", 0, 3, n);
    drive(1'b0, 1'b0);
    wait_for(1'b0, 60);
    drive(1'b0, 1'b1);
    wait_for(1'b1, 20);
    cmp_span("wake ignored awake", 20, 20, n);
    drive(1'b0, 1'b0);
  endtask
  task automatic t_bus();
    apb(1'b0, 12'h020, 32'h0000_0000);
    cmp("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    cmp("unmapped data", 32'h0000_0000, rd);
    apb(1'b0, `ADDR_OPTION, 32'h0000_0000);
    cmp("option read", 32'h0000_0000, rd);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
    cmp("irq status", 32'h0000_000D, rd);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    t_por();
    t_modes();
    t_pin_off();
    t_rate();
    t_wdt();
    t_sleep();
    t_bus();
    close_out();
  end
  initial begin
    #200_000;
    fails++;
    close_out();
  end
endmodule
